// ===== peripheral_irq_flag_enable_bank_bench.sv
// Self-checking bench for the peripheral interrupt bank.
`timescale 1ns/1ns
`default_nettype none
`include "pifb_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
// ****************************************
// Bench top
// ****************************************
module peripheral_irq_flag_enable_bank_bench;
   import pifb_pkg::*;
   logic           clock = 1'b0;
   logic           srst, avs_read, avs_write, avs_waitrequest, pm_en, g_en, req, irq;
   logic           uart_rx_data_read, uart_tx_data_write, c2p, c1p, cc, we;
   logic [3:0]     avs_address, avs_byteenable;
   logic [31:0]    avs_writedata, avs_readdata;
   logic [1:0]     avs_response;
   logic [7:0]     f1, f2, e1, e2, k, w;
   pifb_events_t   fire, ev;
   pifb_ccp_mode_t ccp_mode;
   int             fail_count, n_tests, i, m, sd;
   pifb_periph_model u_src (.clock(clock), .srst(srst), .fire(fire), .events(ev));
   pifb_irq_bank #(.FLAG_WIDTH(8)) dut (.clock(clock), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .events(ev), .ccp_mode(ccp_mode),
      .uart_rx_data_read(uart_rx_data_read), .uart_tx_data_write(uart_tx_data_write),
      .peripheral_irq_master_enable(pm_en), .global_irq_enable(g_en),
      .periph_irq_request(req), .irq(irq));
   // Free-running 250 MHz clock.
   initial begin
      forever #2 clock = ~clock;
   end
   // Reference model of the four registers, updated on the same edges as the bank.
   always @(posedge clock) begin
      we = avs_write && !avs_waitrequest && avs_byteenable[0];
      w = avs_writedata[7:0];
      cc = (ccp_mode == PIFB_CCP_CAPTURE && ev.capture_event) ||
           (ccp_mode == PIFB_CCP_COMPARE && ev.compare_match);
      c2p <= ev.comparator_two_output;
      c1p <= ev.comparator_one_output;
      if (srst) begin
         {f1, f2, e1, e2} <= '0;
      end else begin
         // A clear only removes bits that no event sets in the same cycle.
         k = f1 & ~((we && avs_address == `PIFB_OFF_FLAGS_ONE) ? (`PIFB_SW_CLR_ONE & ~w) : 8'h00);
         f1 <= {1'b0, ev.adc_done | k[6], !uart_rx_data_read & ev.uart_rx_full,
                !uart_tx_data_write & ev.uart_tx_empty, ev.sync_serial_done | k[3],
                cc | k[2], ev.timer_two_match | k[1], ev.timer_one_overflow | k[0]};
         k = f2 & ~((we && avs_address == `PIFB_OFF_FLAGS_TWO) ? (`PIFB_MASK_TWO & ~w) : 8'h00);
         f2 <= k | {ev.osc_fail, ev.comparator_two_output ^ c2p,
                    ev.comparator_one_output ^ c1p, ev.eeprom_write_done, 4'h0};
         if (we && avs_address == `PIFB_OFF_ENABLE_TWO) e2 <= w & `PIFB_MASK_TWO;
         if (we && avs_address == `PIFB_OFF_ENABLE_ONE) e1 <= w & `PIFB_MASK_ONE;
      end
   end
   // Request and irq are compared every cycle once they have settled.
   always @(negedge clock) begin
      if (!srst) begin
         `CHK(req, (|((f1 & e1) | (f2 & e2))) & pm_en);
         `CHK(irq, (|((f1 & e1) | (f2 & e2))) & pm_en & g_en);
      end
   end
   // Expected register contents at an address; holes read zero.
   function automatic logic [31:0] rexp(input logic [3:0] a);
      case (a)
         `PIFB_OFF_ENABLE_TWO: rexp = {24'h0, e2};
         `PIFB_OFF_FLAGS_ONE: rexp = {24'h0, f1};
         `PIFB_OFF_FLAGS_TWO: rexp = {24'h0, f2};
         `PIFB_OFF_ENABLE_ONE: rexp = {24'h0, e1};
         default: rexp = 32'h0;
      endcase
   endfunction : rexp
   // One Avalon access, held until waitrequest is sampled low; reads are compared.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] be);
      @(posedge clock);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'($urandom), d};
      avs_byteenable <= be;
      // No cycle count is assumed; only the watchdog ends a wait that never finishes.
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      if (!wr) `CHK(avs_readdata, rexp(a));
      `CHK(avs_response, (a[1:0] == 2'b00) ? 2'b00 : 2'b10);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   // A one-cycle command to the event source.
   task automatic pulse(input pifb_events_t e);
      @(posedge clock);
      fire <= e;
      @(posedge clock);
      fire <= '0;
   endtask : pulse
   // Reads every mapped register.
   task automatic read_all();
      for (int j = 0; j < 16; j += 4) bus(1'b0, 4'(j), 8'h00, 4'hF);
   endtask : read_all
   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   // Main sequence.
   initial begin
      srst = 1'b1;
      {avs_address, avs_read, avs_write, avs_byteenable, avs_writedata} = '0;
      {fire, uart_rx_data_read, uart_tx_data_write, pm_en, g_en} = '0;
      ccp_mode = PIFB_CCP_CAPTURE;
      sd = $urandom(2);
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      for (i = 0; i < 16; i += 2) bus(1'b0, 4'(i), 8'h00, 4'hF);
      bus(1'b1, `PIFB_OFF_ENABLE_TWO, 8'hFF, 4'hE);
      bus(1'b1, `PIFB_OFF_ENABLE_TWO, 8'hFF, 4'hF);
      bus(1'b1, `PIFB_OFF_ENABLE_ONE, 8'hFF, 4'h1);
      read_all();
      g_en <= 1'b1;
      for (i = 0; i < 12; i++) pulse(12'(1 << i));
      read_all();
      pm_en <= 1'b1;
      @(posedge clock);
      uart_rx_data_read <= 1'b1;
      uart_tx_data_write <= 1'b1;
      @(posedge clock);
      uart_rx_data_read <= 1'b0;
      uart_tx_data_write <= 1'b0;
      bus(1'b1, `PIFB_OFF_FLAGS_ONE, 8'h00, 4'hF);
      bus(1'b1, `PIFB_OFF_FLAGS_TWO, 8'h00, 4'hF);
      read_all();
      for (m = 0; m < 4; m++) begin
         ccp_mode <= pifb_ccp_mode_t'(m);
         pulse(12'h0C0);
         bus(1'b0, `PIFB_OFF_FLAGS_ONE, 8'h00, 4'hF);
         bus(1'b1, `PIFB_OFF_FLAGS_ONE, 8'hB0, 4'hF);
      end
      // Random events race random register writes and data accesses.
      fork
         repeat (400) begin
            @(posedge clock);
            fire <= 12'($urandom & $urandom & $urandom);
            uart_rx_data_read <= ($urandom % 8) == 0;
            uart_tx_data_write <= ($urandom % 8) == 0;
            pm_en <= ($urandom % 4) != 0;
            g_en <= ($urandom % 4) != 0;
         end
         repeat (60) bus(1'b1, 4'($urandom), 8'($urandom), 4'($urandom));
      join
      fire <= '0;
      repeat (3) @(posedge clock);
      read_all();
      end_sim();
   end
   // Watchdog against a hung handshake.
   initial begin
      #100000;
      fail_count++;
      end_sim();
   end
endmodule : peripheral_irq_flag_enable_bank_bench
`default_nettype wire

// ===== pifb_edge_detect.sv
// Change detector for a comparator output level.
`timescale 1ns/1ns
`default_nettype none
module pifb_edge_detect
   import pifb_pkg::*;
(
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic level,
   output logic      changed
);

   logic last_level;
   logic primed;

   // The first sample after reset only primes the detector, avoiding a spurious change.
   always_ff @(posedge clock) begin
      if (srst) begin
         last_level <= 1'b0;
         primed     <= 1'b0;
      end else begin
         last_level <= level;
         primed     <= 1'b1;
      end
   end

   // Either direction of change counts.
   assign changed = primed & (level ^ last_level);

endmodule : pifb_edge_detect
`default_nettype wire

// ===== pifb_irq_bank.sv
// Peripheral interrupt enable and flag register bank with an Avalon-MM slave.
`timescale 1ns/1ns
`default_nettype none
`include "pifb_params.svh"
module pifb_irq_bank
   import pifb_pkg::*;
#(
   parameter int FLAG_WIDTH = 8
)
(
   input  wire logic                   clock,
   input  wire logic                   srst,
   input  wire logic [3:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [3:0]             avs_byteenable,
   input  wire logic [31:0]            avs_writedata,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   output logic [1:0]                  avs_response,
   input  wire pifb_events_t           events,
   input  wire pifb_ccp_mode_t         ccp_mode,
   input  wire logic                   uart_rx_data_read,
   input  wire logic                   uart_tx_data_write,
   input  wire logic                   peripheral_irq_master_enable,
   input  wire logic                   global_irq_enable,
   output logic                        periph_irq_request,
   output logic                        irq
);

   // ************************************************************
   // Bus decode
   // ************************************************************
   pifb_bus_req_t   req;
   pifb_bus_state_t bus_state;
   pifb_bus_state_t next_bus_state;
   logic            accept;
   logic            wr_lane0;

   assign req = '{address: avs_address, read: avs_read, write: avs_write,
                  byteenable: avs_byteenable, writedata: avs_writedata};

   // Returns one when the offset selects an implemented register.
   function automatic logic is_mapped(input logic [3:0] addr);
      is_mapped = (addr == `PIFB_OFF_ENABLE_TWO) || (addr == `PIFB_OFF_FLAGS_ONE) ||
                  (addr == `PIFB_OFF_FLAGS_TWO)  || (addr == `PIFB_OFF_ENABLE_ONE);
   endfunction : is_mapped

   // Every access takes exactly one wait cycle; the second cycle completes it.
   always_comb begin
      case (bus_state)
         PIFB_BUS_IDLE: next_bus_state = (req.read || req.write) ? PIFB_BUS_DONE : PIFB_BUS_IDLE;
         PIFB_BUS_DONE: next_bus_state = PIFB_BUS_IDLE;
         default:       next_bus_state = PIFB_BUS_IDLE;
      endcase
   end

   // Access phase register.
   always_ff @(posedge clock) begin
      if (srst) begin
         bus_state <= PIFB_BUS_IDLE;
      end else begin
         bus_state <= next_bus_state;
      end
   end

   // Waitrequest is high in the first cycle of a request and low in the second.
   assign accept          = (bus_state == PIFB_BUS_DONE) && (req.read || req.write);
   assign avs_waitrequest = (req.read || req.write) && (bus_state != PIFB_BUS_DONE);
   assign wr_lane0        = accept && req.write && req.byteenable[0];

   // ************************************************************
   // Enable registers
   // ************************************************************
   logic [7:0] enable_one;
   logic [7:0] periph_irq_enable_two;

   // Enable writes keep only implemented bits, so unused bits read zero.
   always_ff @(posedge clock) begin
      if (srst) begin
         enable_one            <= `PIFB_RESET_VALUE;
         periph_irq_enable_two <= `PIFB_RESET_VALUE;
      end else if (wr_lane0) begin
         if (req.address == `PIFB_OFF_ENABLE_ONE) begin
            enable_one <= req.writedata[7:0] & `PIFB_MASK_ONE;
         end
         if (req.address == `PIFB_OFF_ENABLE_TWO) begin
            periph_irq_enable_two <= req.writedata[7:0] & `PIFB_MASK_TWO;
         end
      end
   end

   // ************************************************************
   // Flag sources
   // ************************************************************
   logic [7:0] set_one;
   logic [7:0] set_two;
   logic [7:0] clr_one;
   logic [7:0] clr_two;
   logic [7:0] periph_irq_flags_one;
   logic [7:0] periph_irq_flags_two;
   logic       cmp_two_changed;
   logic       cmp_one_changed;
   logic       ccp_event;

   pifb_edge_detect u_cmp_two (
      .clock   (clock),
      .srst    (srst),
      .level   (events.comparator_two_output),
      .changed (cmp_two_changed)
   );

   pifb_edge_detect u_cmp_one (
      .clock   (clock),
      .srst    (srst),
      .level   (events.comparator_one_output),
      .changed (cmp_one_changed)
   );

   // The capture/compare source depends on mode; PWM and off raise nothing.
   always_comb begin
      case (ccp_mode)
         PIFB_CCP_CAPTURE: ccp_event = events.capture_event;
         PIFB_CCP_COMPARE: ccp_event = events.compare_match;
         default:          ccp_event = 1'b0;
      endcase
   end

   // Set vectors ignore the enables entirely.
   always_comb begin
      set_one = 8'h00;
      set_one[`PIFB_F1_ADC]         = events.adc_done;
      set_one[`PIFB_F1_SYNC_SERIAL] = events.sync_serial_done;
      set_one[`PIFB_F1_CAPCOMP]     = ccp_event;
      set_one[`PIFB_F1_TIMER_TWO]   = events.timer_two_match;
      set_one[`PIFB_F1_TIMER_ONE]   = events.timer_one_overflow;
      set_two = 8'h00;
      set_two[`PIFB_F2_OSC_FAIL]    = events.osc_fail;
      set_two[`PIFB_F2_CMP_TWO]     = cmp_two_changed;
      set_two[`PIFB_F2_CMP_ONE]     = cmp_one_changed;
      set_two[`PIFB_F2_EEPROM]      = events.eeprom_write_done;
   end

   // A written zero clears a software-clearable flag; ones leave it alone.
   assign clr_one = (wr_lane0 && req.address == `PIFB_OFF_FLAGS_ONE) ?
                    (~req.writedata[7:0] & `PIFB_SW_CLR_ONE) : 8'h00;
   assign clr_two = (wr_lane0 && req.address == `PIFB_OFF_FLAGS_TWO) ?
                    (~req.writedata[7:0] & `PIFB_MASK_TWO) : 8'h00;

   // One sticky cell per implemented software-cleared bit.
   genvar gi;
   generate
      for (gi = 0; gi < FLAG_WIDTH; gi++) begin : g_flag
         if (((`PIFB_SW_CLR_ONE >> gi) & 1) != 0) begin : g_one
            pifb_sticky_flag u_f1 (
               .clock     (clock),
               .srst      (srst),
               .set_pulse (set_one[gi]),
               .sw_clear  (clr_one[gi]),
               .flag      (periph_irq_flags_one[gi])
            );
         end else if (gi == `PIFB_F1_UART_RX || gi == `PIFB_F1_UART_TX) begin : g_uart
            // Filled by the UART status logic below.
         end else begin : g_one_zero
            assign periph_irq_flags_one[gi] = 1'b0;
         end
         if (((`PIFB_MASK_TWO >> gi) & 1) != 0) begin : g_two
            pifb_sticky_flag u_f2 (
               .clock     (clock),
               .srst      (srst),
               .set_pulse (set_two[gi]),
               .sw_clear  (clr_two[gi]),
               .flag      (periph_irq_flags_two[gi])
            );
         end else begin : g_two_zero
            assign periph_irq_flags_two[gi] = 1'b0;
         end
      end
   endgenerate

   // ************************************************************
   // UART status flags, read-only
   // ************************************************************
   logic rx_flag;
   logic tx_flag;

   // The flags track the buffer state one edge late; a data access drops them at the next edge for a cycle
   // so the request does not linger while the buffer status catches up.
   always_ff @(posedge clock) begin
      if (srst) begin
         rx_flag <= 1'b0;
         tx_flag <= 1'b0;
      end else begin
         rx_flag <= events.uart_rx_full && !uart_rx_data_read;
         tx_flag <= events.uart_tx_empty && !uart_tx_data_write;
      end
   end

   assign periph_irq_flags_one[`PIFB_F1_UART_RX] = rx_flag;
   assign periph_irq_flags_one[`PIFB_F1_UART_TX] = tx_flag;

   // ************************************************************
   // Combined request and interrupt output
   // ************************************************************
   logic any_pending;

   // Software should clear a flag before enabling it; nothing here hides a stale flag.
   assign any_pending = |(periph_irq_flags_one & enable_one) |
                        |(periph_irq_flags_two & periph_irq_enable_two);

   // Master enable gates everything regardless of individual enables.
   assign periph_irq_request = any_pending && peripheral_irq_master_enable;
   assign irq                = periph_irq_request && global_irq_enable;

   // ************************************************************
   // Read data
   // ************************************************************
   // Read data is registered and valid in the cycle waitrequest drops.
   always_ff @(posedge clock) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
         avs_response <= 2'h0;
      end else if (req.read && bus_state == PIFB_BUS_IDLE) begin
         avs_response <= is_mapped(req.address) ? 2'h0 : 2'h2;
         case (req.address)
            `PIFB_OFF_ENABLE_ONE: avs_readdata <= {24'h000000, enable_one};
            `PIFB_OFF_ENABLE_TWO: avs_readdata <= {24'h000000, periph_irq_enable_two};
            `PIFB_OFF_FLAGS_ONE:  avs_readdata <= {24'h000000, periph_irq_flags_one};
            `PIFB_OFF_FLAGS_TWO:  avs_readdata <= {24'h000000, periph_irq_flags_two};
            default:              avs_readdata <= 32'h0000_0000;
         endcase
      end else if (req.write && bus_state == PIFB_BUS_IDLE) begin
         avs_response <= is_mapped(req.address) ? 2'h0 : 2'h2;
      end
   end

endmodule : pifb_irq_bank
`default_nettype wire

// ===== pifb_params.svh
// Register offsets, field positions and reset values of the peripheral interrupt bank.
`ifndef PIFB_PARAMS_SVH
`define PIFB_PARAMS_SVH

// ************************************************************
// Register byte offsets on the Avalon-MM slave
// ************************************************************
`define PIFB_OFF_ENABLE_TWO  4'h0
`define PIFB_OFF_FLAGS_ONE   4'h4
`define PIFB_OFF_FLAGS_TWO   4'h8
`define PIFB_OFF_ENABLE_ONE  4'hC

// ************************************************************
// Field positions
// ************************************************************
`define PIFB_F1_ADC          6
`define PIFB_F1_UART_RX      5
`define PIFB_F1_UART_TX      4
`define PIFB_F1_SYNC_SERIAL  3
`define PIFB_F1_CAPCOMP      2
`define PIFB_F1_TIMER_TWO    1
`define PIFB_F1_TIMER_ONE    0
`define PIFB_F2_OSC_FAIL     7
`define PIFB_F2_CMP_TWO      6
`define PIFB_F2_CMP_ONE      5
`define PIFB_F2_EEPROM       4

// ************************************************************
// Implemented-bit masks and reset values
// ************************************************************
`define PIFB_MASK_ONE        8'h7F
`define PIFB_MASK_TWO        8'hF0
`define PIFB_SW_CLR_ONE      8'h4F
`define PIFB_RESET_VALUE     8'h00

`endif

// ===== pifb_periph_model.sv
// Event source standing in for the timers, serial ports and comparators.
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Event source
// ****************************************
module pifb_periph_model
   import pifb_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         srst,
   input  wire pifb_events_t fire,
   output var pifb_events_t  events
);
   // Buffer and comparator levels toggle on command; all others are one-cycle pulses.
   localparam logic [11:0] LEVELS = 12'h606;
   // Levels start low after reset, so no comparator change is seen while it releases.
   always_ff @(posedge clock) begin
      if (srst) begin
         events <= '0;
      end else begin
         events <= (fire & ~LEVELS) | ((events ^ fire) & LEVELS);
      end
   end
endmodule : pifb_periph_model
`default_nettype wire

// ===== pifb_pkg.sv
// Types shared by the peripheral interrupt bank.
package pifb_pkg;

   // Avalon-MM request from the bus master.
   typedef struct packed {
      logic [3:0] address;
      logic       read;
      logic       write;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } pifb_bus_req_t;

   // Pulses and levels from the peripherals.
   typedef struct packed {
      logic adc_done;
      logic uart_rx_full;
      logic uart_tx_empty;
      logic sync_serial_done;
      logic capture_event;
      logic compare_match;
      logic timer_two_match;
      logic timer_one_overflow;
      logic osc_fail;
      logic comparator_two_output;
      logic comparator_one_output;
      logic eeprom_write_done;
   } pifb_events_t;

   // Capture/compare unit operating mode.
   typedef enum logic [1:0] {
      PIFB_CCP_CAPTURE = 2'h0,
      PIFB_CCP_COMPARE = 2'h1,
      PIFB_CCP_PWM     = 2'h2,
      PIFB_CCP_OFF     = 2'h3
   } pifb_ccp_mode_t;

   // Bus slave access phases, one-hot.
   typedef enum logic [1:0] {
      PIFB_BUS_IDLE = 2'b01,
      PIFB_BUS_DONE = 2'b10
   } pifb_bus_state_t;

endpackage : pifb_pkg

// ===== pifb_props.sv
// Concurrent checks on the ports of the peripheral interrupt bank.
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module pifb_props
   import pifb_pkg::*;
(
   input wire logic         clock,
   input wire logic         srst,
   input wire logic [3:0]   avs_address,
   input wire logic         avs_read,
   input wire logic         avs_write,
   input wire logic [31:0]  avs_readdata,
   input wire logic         avs_waitrequest,
   input wire logic [1:0]   avs_response,
   input wire pifb_events_t events,
   input wire logic         peripheral_irq_master_enable,
   input wire logic         global_irq_enable,
   input wire logic         periph_irq_request,
   input wire logic         irq
);
   // Only word offsets are decoded, so any low address bit marks a hole.
   wire mapped = (avs_address[1:0] == 2'b00);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // The two steps of one bus access.
   sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_done; (avs_read || avs_write) && !avs_waitrequest; endsequence
   a_wait_once: assert property (s_req |=> s_done)
      else $error("bus access not completed after one wait cycle");
   a_master_gate: assert property (!peripheral_irq_master_enable |-> !periph_irq_request)
      else $error("peripheral request without master enable");
   a_irq_global: assert property (irq == (periph_irq_request && global_irq_enable))
      else $error("irq does not follow request and global enable");
   // Uart levels are excluded because those flags follow their buffers.
   a_flag_sticky: assert property (periph_irq_request && !avs_write &&
      !events.uart_rx_full && !events.uart_tx_empty &&
      !$past(events.uart_rx_full || events.uart_tx_empty)
      |=> !peripheral_irq_master_enable || periph_irq_request)
      else $error("pending request dropped without software action");
   a_top_bit_zero: assert property (s_done ##0 (avs_read && avs_address == 4'h4)
      |-> !avs_readdata[7])
      else $error("flags one bit 7 read as one");
   a_low_nibble_zero: assert property (s_done ##0 (avs_read &&
      (avs_address == 4'h0 || avs_address == 4'h8)) |-> avs_readdata[3:0] == 4'h0)
      else $error("unimplemented low bits read as one");
   a_hole_resp: assert property (s_done ##0 !mapped |-> avs_response == 2'b10)
      else $error("unmapped access without error response");
   a_hole_zero: assert property (s_done ##0 (avs_read && !mapped) |-> avs_readdata == 32'h0)
      else $error("unmapped read returned data");
   a_reset_quiet: assert property ($fell(srst) |-> !periph_irq_request && !irq)
      else $error("request high right after reset");
endmodule : pifb_props
bind pifb_irq_bank pifb_props u_props (
   .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .avs_response(avs_response), .events(events),
   .peripheral_irq_master_enable(peripheral_irq_master_enable),
   .global_irq_enable(global_irq_enable), .periph_irq_request(periph_irq_request), .irq(irq));
`default_nettype wire

// ===== pifb_sticky_flag.sv
// One software-cleared sticky flag with hardware set priority.
`timescale 1ns/1ns
`default_nettype none
module pifb_sticky_flag
   import pifb_pkg::*;
(
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic set_pulse,
   input  wire logic sw_clear,
   output var  logic flag
);

   // Set beats clear so that an event in the clearing cycle survives.
   always_ff @(posedge clock) begin
      if (srst) begin
         flag <= 1'b0;
      end else if (set_pulse) begin
         flag <= 1'b1;
      end else if (sw_clear) begin
         flag <= 1'b0;
      end
   end

endmodule : pifb_sticky_flag
`default_nettype wire
